// ### rtl/psrc_status.sv
// Status report engine: command word decode, error flags, parameter block.
// Assumes event inputs and command strobe arrive from logic on clk_sys;
// only rst_n is asynchronous.
//
// Operation
// - Code 16 reports status words and leaves stored status unchanged.
// - Code 17 reports status then clears only the error flags that report showed.
// - Summary bit 15 is OR of all six error flags.
// - Summary set also sets interrupt flag and raises host interrupt.
// - Repeated timeout or ring error before clear sets bit 14.
// - Transmitter active for the whole maximum frame time sets bit 13.
// - Missing collision test signal after transmission sets bit 12.
// - Collision test error only sets while enable bit is set.
// - Bus timeout or nonexistent address on ring access sets bit 11.
// - Receive ring access error sets bit 9.
// - Transmit ring access error sets bit 8.
// - Bit 7 reports patched microcode.
// - Bit 6 reports microcode running from RAM.
// - Bits 5:0 report six-bit microcode revision.
// - Third word high byte holds multicast count, zero at reset.
// - Third word low byte reports capacity of ten.
// - Fourth word reports counter block length 34.
// - Enabled collision test error interrupts via error summary.
`timescale 1ns/1ps
module psrc_status (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word,
	output logic             cmd_done,
	output logic             cmd_error,
	input  wire logic [2:0]  blk_addr,
	output logic      [15:0] blk_rdata,
	input  wire logic        collision_test_enable,
	input  wire logic        tx_active,
	input  wire logic        tx_end,
	input  wire logic        collision_seen,
	input  wire logic        bus_timeout_evt,
	input  wire logic        rx_ring_evt,
	input  wire logic        tx_ring_evt,
	input  wire logic        microcode_modified_flag,
	input  wire logic        ram_microcode_active,
	input  wire logic [5:0]  microcode_revision,
	input  wire logic [7:0]  multicast_in_use_count,
	input  wire logic        status_error_interrupt_clear,
	output logic             status_error_interrupt,
	output logic             host_irq
);

	// ************************************************************
	// Reset release
	// ************************************************************
	logic rst_meta_q;
	logic rst_sync_n_q;

	// Two-stage release keeps deassertion synchronous
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q   <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q   <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	// ************************************************************
	// Error flags
	// ************************************************************
	logic [5:0]  flags_q;
	logic [5:0]  flags_d;
	logic [31:0] tx_cnt_q;
	logic [31:0] tx_cnt_d;
	logic        overlong_evt;
	logic        coll_evt;
	logic        clear_now;
	logic        summary;
	logic        summary_q;
	logic        status_error_interrupt_q;
	logic        status_error_interrupt_d;
	logic [5:0]  rep_flags;
	// flags_q: [5]repeat [4]overlong [3]colltest [2]timeout [1]rx ring [0]tx ring

	always_comb begin
		tx_cnt_d = tx_active ? tx_cnt_q + 32'h1 : 32'h0;
		// Holds at the limit only while still sending; idle always restarts it
		if (tx_active && (tx_cnt_q == 32'(psrc_pkg::OVERLONG_CYCLES)))
			tx_cnt_d = tx_cnt_q;
	end
	assign overlong_evt = tx_active && (tx_cnt_q == 32'(psrc_pkg::OVERLONG_CYCLES - 1));

	assign coll_evt = tx_end && !collision_seen && collision_test_enable;

	// Flag update; a new event wins over the clear in the same cycle
	always_comb begin
		flags_d = flags_q;
		// flags raised after the snapshot are kept
		if (clear_now)
			flags_d = flags_q & ~rep_flags;
		// repeat of an already set flag
		if ((bus_timeout_evt && flags_q[2]) || (rx_ring_evt && flags_q[1]) ||
		    (tx_ring_evt && flags_q[0]))
			flags_d[5] = 1'b1;
		if (overlong_evt)
			flags_d[4] = 1'b1;
		if (coll_evt)
			flags_d[3] = 1'b1;
		if (bus_timeout_evt)
			flags_d[2] = 1'b1;
		if (rx_ring_evt)
			flags_d[1] = 1'b1;
		if (tx_ring_evt)
			flags_d[0] = 1'b1;
	end

	assign summary = |flags_q;

	// rising summary sets interrupt flag; set wins over clear
	always_comb begin
		status_error_interrupt_d = status_error_interrupt_q;
		if (status_error_interrupt_clear)
			status_error_interrupt_d = 1'b0;
		if (summary && !summary_q)
			status_error_interrupt_d = 1'b1;
	end
	assign status_error_interrupt = status_error_interrupt_q;
	assign host_irq               = status_error_interrupt_q;

	always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			flags_q   <= 6'h00;
			tx_cnt_q  <= 32'h0;
			summary_q <= 1'b0;
			status_error_interrupt_q    <= 1'b0;
		end else begin
			flags_q   <= flags_d;
			tx_cnt_q  <= tx_cnt_d;
			summary_q <= summary;
			status_error_interrupt_q    <= status_error_interrupt_d;
		end
	end

	// ************************************************************
	// Command sequencer and parameter block
	// ************************************************************
	psrc_pkg::psrc_state_t state_q;
	psrc_pkg::psrc_state_t state_d;
	logic [15:0] cmd_q, cmd_d;
	logic [15:0] stat_q, stat_d;
	logic [15:0] mcast_q, mcast_d;
	logic [15:0] ctr_q, ctr_d;
	logic [15:0] live_stat;
	logic        good_op;
	logic        err_q, err_d;

	// Live status word; bit 10 reads zero
	assign live_stat = {summary, flags_q[5:3], flags_q[2], 1'b0, flags_q[1:0],
	                    microcode_modified_flag, ram_microcode_active,
	                    microcode_revision};
	assign good_op = (cmd_word[15:8] == 8'h00) &&
	                 ((cmd_word[7:0] == psrc_pkg::OP_READ_STATUS) ||
	                  (cmd_word[7:0] == psrc_pkg::OP_READ_CLEAR));

	// flags the snapshot reported; a later error on a flag it did not show is never lost
	assign rep_flags = {stat_q[psrc_pkg::BIT_REPEAT], stat_q[psrc_pkg::BIT_OVERLONG],
	                    stat_q[psrc_pkg::BIT_COLLTEST], stat_q[psrc_pkg::BIT_TIMEOUT],
	                    stat_q[psrc_pkg::BIT_RX_RING], stat_q[psrc_pkg::BIT_TX_RING]};

	// Snapshot taken in WRITE, clear applied in DONE so reported value predates it
	always_comb begin
		state_d   = state_q;
		cmd_d     = cmd_q;
		stat_d    = stat_q;
		mcast_d   = mcast_q;
		ctr_d     = ctr_q;
		err_d     = err_q;
		clear_now = 1'b0;
		cmd_done  = 1'b0;
		case (state_q)
			psrc_pkg::PSRC_IDLE: begin
				if (cmd_valid) begin
					cmd_d   = cmd_word;
					err_d   = !good_op;
					state_d = psrc_pkg::PSRC_WRITE;
				end
			end
			psrc_pkg::PSRC_WRITE: begin
				if (!err_q) begin
					stat_d  = live_stat;
					mcast_d = {multicast_in_use_count, psrc_pkg::MULTICAST_CAPACITY};
					ctr_d   = psrc_pkg::COUNTER_BLOCK_WORDS;
				end
				state_d = psrc_pkg::PSRC_DONE;
			end
			psrc_pkg::PSRC_DONE: begin
				clear_now = !err_q && (cmd_q[7:0] == psrc_pkg::OP_READ_CLEAR);
				cmd_done  = 1'b1;
				state_d   = psrc_pkg::PSRC_IDLE;
			end
			default: state_d = psrc_pkg::PSRC_IDLE;
		endcase
	end
	assign cmd_error = cmd_done && err_q;

	always_ff @(posedge clk_sys or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			state_q <= psrc_pkg::PSRC_IDLE;
			cmd_q   <= psrc_pkg::WORD_RESET;
			stat_q  <= psrc_pkg::WORD_RESET;
			mcast_q <= {psrc_pkg::MULTICAST_RESET, psrc_pkg::MULTICAST_CAPACITY};
			ctr_q   <= psrc_pkg::COUNTER_BLOCK_WORDS;
			err_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cmd_q   <= cmd_d;
			stat_q  <= stat_d;
			mcast_q <= mcast_d;
			ctr_q   <= ctr_d;
			err_q   <= err_d;
		end
	end

	// Parameter block read port; unmapped words read zero
	always_comb begin
		case (blk_addr)
			psrc_pkg::OFF_COMMAND:    blk_rdata = cmd_q;
			psrc_pkg::OFF_STATUS:     blk_rdata = stat_q;
			psrc_pkg::OFF_MULTICAST:  blk_rdata = mcast_q;
			psrc_pkg::OFF_CTR_LENGTH: blk_rdata = ctr_q;
			default:                  blk_rdata = 16'h0000;
		endcase
	end

	// ************************************************************
	// Checks
	// ************************************************************
	sequence clr_cmd_s;
		state_q == psrc_pkg::PSRC_DONE && !err_q && cmd_q[7:0] == psrc_pkg::OP_READ_CLEAR;
	endsequence

	read_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		(cmd_done && cmd_q[7:0] == psrc_pkg::OP_READ_STATUS) |->
		##1 ((flags_q & $past(flags_q)) == $past(flags_q)))
		else $error("read status altered flags");
	clear_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		(clr_cmd_s and !bus_timeout_evt && !rx_ring_evt && !tx_ring_evt && !overlong_evt && !coll_evt)
		|=> (flags_q & $past(rep_flags)) == 6'h00)
		else $error("read and clear left flags set");
	bad_op_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		(state_q == psrc_pkg::PSRC_IDLE && cmd_valid && cmd_word[15:8] != 8'h00) |=> ##1 cmd_error)
		else $error("nonzero high byte not refused");
	summary_or_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		(state_q == psrc_pkg::PSRC_DONE && !err_q) |-> stat_q[15] == (|stat_q[14:8]))
		else $error("summary not OR of flags");
	irq_raise_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		$rose(summary) |=> host_irq)
		else $error("summary did not raise interrupt");
	repeat_err_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		(rx_ring_evt && flags_q[1]) |=> flags_q[5])
		else $error("repeated error not flagged");
	coll_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		(!flags_q[3] && !collision_test_enable) |=> !flags_q[3])
		else $error("collision flag set while disabled");
	timeout_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		bus_timeout_evt |=> flags_q[2] && summary)
		else $error("timeout flag not set");
	fixed_words_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		cmd_done |-> ctr_q == 16'h0022 && mcast_q[7:0] == 8'h0a)
		else $error("fixed report words wrong");
	snap_before_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		clr_cmd_s |=> stat_q == $past(stat_q))
		else $error("snapshot changed by clear");

	// Snapshot cycle of a read-and-clear command
	sequence clr_write_s;
		state_q == psrc_pkg::PSRC_WRITE && !err_q && cmd_q[7:0] == psrc_pkg::OP_READ_CLEAR;
	endsequence

	late_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		(clr_write_s and rx_ring_evt && !flags_q[1]) |=> ##1 flags_q[1])
		else $error("error after snapshot lost by clear");
	tx_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		!tx_active |=> tx_cnt_q == 32'h0)
		else $error("transmit timer not restarted");
	overlong_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_q)
		overlong_evt |=> flags_q[4] && summary)
		else $error("overlong flag not set");
endmodule

// ### rtl/psrc_pkg.sv
// Constants for the port status read and clear block.
// Assumes a single 100 MHz clock domain.
package psrc_pkg;
	// Parameter block word offsets (byte addresses, 16-bit words)
	localparam logic [2:0] OFF_COMMAND    = 3'h0;
	localparam logic [2:0] OFF_STATUS     = 3'h2;
	localparam logic [2:0] OFF_MULTICAST  = 3'h4;
	localparam logic [2:0] OFF_CTR_LENGTH = 3'h6;
	// Operation codes
	localparam logic [7:0] OP_READ_STATUS  = 8'h10;
	localparam logic [7:0] OP_READ_CLEAR   = 8'h11;
	// Status word bit positions
	localparam int BIT_SUMMARY   = 15;
	localparam int BIT_REPEAT    = 14;
	localparam int BIT_OVERLONG  = 13;
	localparam int BIT_COLLTEST  = 12;
	localparam int BIT_TIMEOUT   = 11;
	localparam int BIT_RX_RING   = 9;
	localparam int BIT_TX_RING   = 8;
	localparam int BIT_MODIFIED  = 7;
	localparam int BIT_RAM_UCODE = 6;
	// Fixed report values
	localparam logic [7:0]  MULTICAST_CAPACITY  = 8'h0a;
	localparam logic [15:0] COUNTER_BLOCK_WORDS = 16'h0022;
	localparam logic [7:0]  MULTICAST_RESET     = 8'h00;
	localparam logic [15:0] WORD_RESET          = 16'h0000;
	// Longest transmit burst: maximum frame 1518 bytes at 10 Mb/s
	localparam int  MAX_FRAME_TIME_NS = 1214400;
	localparam int  CLK_PERIOD_NS     = 10;
	localparam int  OVERLONG_CYCLES   = MAX_FRAME_TIME_NS / CLK_PERIOD_NS;
	// Command sequencer states
	typedef enum logic [2:0] {
		PSRC_IDLE  = 3'b001,
		PSRC_WRITE = 3'b010,
		PSRC_DONE  = 3'b100
	} psrc_state_t;
endpackage

// ### tb/psrc_host_model.sv
// Host port driver model: offers command words to the status block.
// Assumes clk_sys runs freely and the block's reset is already released.
`timescale 1ns/1ps
module psrc_host_model (
	input  wire logic        clk_sys,
	output logic             cmd_valid,
	output logic      [15:0] cmd_word,
	input  wire logic        cmd_done
);
	// ****************
	// Command offer
	// ****************
	// opcode low byte, high byte zero unless a test asks otherwise
	task automatic issue(input logic [7:0] op, input logic [7:0] hi, input int gap);
		repeat (gap + 1) @(posedge clk_sys);
		#1 cmd_valid = 1'b1;
		cmd_word = {hi, op};
		@(posedge clk_sys);
		#1 cmd_valid = 1'b0;
		// Released word toggles so stale data never looks like a command
		cmd_word = ~cmd_word;
		for (int i = 0; i < 6 && cmd_done !== 1'b1; i++) @(negedge clk_sys);
	endtask
	// Idle values at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
	end
endmodule

// ### tb/port_status_read_clear_tb.sv
// Self-checking bench for the status report engine.
// Assumes the host model issues commands; the bench drives event inputs.
`timescale 1ns/1ps
module port_status_read_clear_tb;
	// ****************
	// Signals
	// ****************
	logic        clk_sys, rst_n, cmd_valid, cmd_done, cmd_error, collision_test_enable;
	logic        tx_active, tx_end, collision_seen, status_error_interrupt_clear, status_error_interrupt, host_irq;
	logic [15:0] cmd_word, blk_rdata;
	logic [2:0]  blk_addr, evt;
	logic [7:0]  uc, mc;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	int          n_fail, n_compared, seed;

	psrc_status dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .cmd_done(cmd_done), .cmd_error(cmd_error),
		.blk_addr(blk_addr), .blk_rdata(blk_rdata),
		.collision_test_enable(collision_test_enable), .tx_active(tx_active),
		.tx_end(tx_end), .collision_seen(collision_seen), .bus_timeout_evt(evt[0]),
		.rx_ring_evt(evt[1]), .tx_ring_evt(evt[2]), .microcode_modified_flag(uc[7]),
		.ram_microcode_active(uc[6]), .microcode_revision(uc[5:0]),
		.multicast_in_use_count(mc), .status_error_interrupt_clear(status_error_interrupt_clear),
		.status_error_interrupt(status_error_interrupt), .host_irq(host_irq));
	psrc_host_model host_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.cmd_done(cmd_done));

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	// ****************
	// Helpers
	// ****************
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Error byte for timeout, receive ring, transmit ring, summary included
	function automatic logic [7:0] hb(input int k);
		return 8'h80 | (k == 0 ? 8'h08 : (k == 1 ? 8'h02 : 8'h01));
	endfunction
	task automatic rd(input logic [2:0] a, input logic [15:0] x);
		@(posedge clk_sys);
		#1 blk_addr = a;
		@(negedge clk_sys);
		check("word", blk_rdata, x);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] hi, input logic [7:0] x, input logic er);
		@(posedge clk_sys);
		#1 blk_addr = psrc_pkg::OFF_STATUS;
		exp_q.push_back({er, x, uc});
		host_u.issue(op, hi, 0);
	endtask
	task automatic pulse(input int k);
		@(posedge clk_sys);
		#1 evt = 3'h1 << k;
		@(posedge clk_sys);
		#1 evt = 3'h0;
	endtask
	task automatic tx(input logic cs);
		@(posedge clk_sys);
		#1 tx_active = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 tx_end = 1'b1;
		collision_seen = cs;
		@(posedge clk_sys);
		#1 tx_end = 1'b0;
		tx_active = 1'b0;
		collision_seen = 1'b0;
	endtask
	// Waits for the interrupt to settle, then checks that flag and pin are set
	task automatic irq_cycle();
		repeat (3) @(posedge clk_sys);
		#1 check("irq", {15'h0000, status_error_interrupt}, 16'h0001);
		check("irq pin", {15'h0000, host_irq}, 16'h0001);
	endtask
	task automatic clr_irq();
		@(posedge clk_sys);
		#1 status_error_interrupt_clear = 1'b1;
		@(posedge clk_sys);
		#1 status_error_interrupt_clear = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 check("irq off", {15'h0000, host_irq}, 16'h0000);
	endtask

	// Scoreboard: each completion takes the oldest note
	always @(negedge clk_sys) begin
		if (cmd_done === 1'b1) begin
			if (exp_q.size() == 0) check("spare done", 16'h0001, 16'h0000);
			else begin
				e = exp_q.pop_front();
				check("status", blk_rdata, e[15:0]);
				check("error", {15'h0000, cmd_error}, {15'h0000, e[16]});
			end
		end
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		close_out();
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		{clk_sys, rst_n, collision_test_enable, tx_active, tx_end, collision_seen} = 6'h00;
		{status_error_interrupt_clear, evt, blk_addr, n_fail, n_compared} = '0;
		seed = 70707;
		uc = 8'($random(seed));
		mc = 8'($random(seed));
		repeat (20) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(psrc_pkg::OFF_COMMAND, psrc_pkg::WORD_RESET);
		rd(psrc_pkg::OFF_MULTICAST, {psrc_pkg::MULTICAST_RESET, psrc_pkg::MULTICAST_CAPACITY});
		rd(psrc_pkg::OFF_CTR_LENGTH, psrc_pkg::COUNTER_BLOCK_WORDS);
		cmd(psrc_pkg::OP_READ_STATUS, 8'h00, 8'h00, 1'b0);
		rd(psrc_pkg::OFF_MULTICAST, {mc, psrc_pkg::MULTICAST_CAPACITY});
		// Each timeout and ring error kind: report, repeat, clear
		for (int k = 0; k < 3; k++) begin
			pulse(k);
			irq_cycle();
			cmd(psrc_pkg::OP_READ_STATUS, 8'h00, hb(k), 1'b0);
			pulse(k);
			cmd(psrc_pkg::OP_READ_CLEAR, 8'h00, hb(k) | 8'h40, 1'b0);
			cmd(psrc_pkg::OP_READ_STATUS, 8'h00, 8'h00, 1'b0);
			clr_irq();
		end
		// Malformed commands neither capture nor clear
		pulse(0);
		cmd(psrc_pkg::OP_READ_CLEAR, 8'h01 | 8'($random(seed)), 8'h00, 1'b1);
		cmd(8'h12, 8'h00, 8'h00, 1'b1);
		cmd(psrc_pkg::OP_READ_CLEAR, 8'h00, hb(0), 1'b0);
		clr_irq();
		// Collision test gated by its enable
		tx(1'b0);
		cmd(psrc_pkg::OP_READ_STATUS, 8'h00, 8'h00, 1'b0);
		@(posedge clk_sys);
		#1 collision_test_enable = 1'b1;
		tx(1'b1);
		cmd(psrc_pkg::OP_READ_STATUS, 8'h00, 8'h00, 1'b0);
		tx(1'b0);
		irq_cycle();
		cmd(psrc_pkg::OP_READ_CLEAR, 8'h00, 8'h90, 1'b0);
		clr_irq();
		// Error arriving in the snapshot cycle of a clear must survive it
		fork
			cmd(psrc_pkg::OP_READ_CLEAR, 8'h00, 8'h00, 1'b0);
			begin
				repeat (2) @(posedge clk_sys);
				pulse(1);
			end
		join
		cmd(psrc_pkg::OP_READ_STATUS, 8'h00, hb(1), 1'b0);
		repeat (4) @(posedge clk_sys);
		// A command that never completed leaves its note behind
		check("pending", 16'(exp_q.size()), 16'h0000);
		close_out();
	end
endmodule
